// File: pld_pkg.sv
// shared constants and types for the second-loop lock-detect block
package pld_pkg;
  // register addresses, 15-bit serial address space
  localparam logic [14:0] ADDR_PD_CTRL   = 15'h0169;
  localparam logic [14:0] ADDR_CNT_HIGH  = 15'h016a;
  localparam logic [14:0] ADDR_CNT_LOW   = 15'h016b;
  localparam logic [14:0] ADDR_LOCK_STAT = 15'h0183;
  // power-on values and writable bits
  localparam logic [7:0] CTRL_RST       = 8'h58;
  localparam logic [7:0] CNT_HIGH_RST   = 8'h00;
  localparam logic [7:0] CNT_LOW_RST    = 8'h00;
  localparam logic [7:0] CTRL_WMASK     = 8'h7f;
  localparam logic [7:0] CNT_HIGH_WMASK = 8'h3f;
  localparam logic [7:0] CNT_LOW_WMASK  = 8'hff;
  // lock status register bit positions
  localparam int STAT_LOCK_BIT   = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  // serial frame: read flag, 15 address bits, 8 data bits
  localparam logic [4:0] LAST_CMD_BIT  = 5'h0f;
  localparam logic [4:0] LAST_DATA_BIT = 5'h17;
  // window selections
  localparam logic [1:0] WIN_RESERVED = 2'h0;
  localparam logic [1:0] WIN_1NS      = 2'h1;
  localparam logic [1:0] WIN_1P8NS    = 2'h2;
  localparam logic [1:0] WIN_2P6NS    = 2'h3;
  // lock count width
  localparam int COUNT_W = 14;

  // phase detector control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       reserved;
    logic [1:0] window;
    logic [1:0] current;
    logic       polarity;
    logic       pump_float;
    logic       force_on;
  } pld_ctrl_t;

  // serial port states, gray along the frame
  typedef enum logic [1:0] {
    PLD_IDLE = 2'b00,
    PLD_CMD  = 2'b01,
    PLD_DATA = 2'b11,
    PLD_HOLD = 2'b10
  } pld_spi_st_t;
endpackage

// File: pld_lock_counter.sv
// consecutive in-window cycle counter for the second-loop lock detect
`timescale 1ns/100ps
`default_nettype none
module pld_lock_counter #(
  parameter int COUNT_W = 14
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // controls
  input  wire logic               enable,
  input  wire logic [1:0]         window,
  input  wire logic [COUNT_W-1:0] target,
  // phase comparison, one sample per detector cycle
  input  wire logic               in_window,
  // result
  output logic                    locked
);
  logic [COUNT_W-1:0] run;
  logic [COUNT_W-1:0] next_run;
  logic               next_locked;
  logic               armed;

  // the run count needs at least one bit
  if (COUNT_W < 1) begin
    $error("COUNT_W must be at least 1");
  end

  // a reserved window or zero count can never lock
  always_comb begin
    armed       = enable && (window != pld_pkg::WIN_RESERVED) &&
                  (target != '0);
    next_run    = '0;
    next_locked = 1'b0;
    if (armed && in_window) begin
      // saturate so a long lock cannot wrap the count
      next_run    = (run < target) ? run + COUNT_W'(1) : run;
      next_locked = (next_run >= target);
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run    <= '0;
      locked <= 1'b0;
    end else begin
      run    <= next_run;
      locked <= next_locked;
    end
  end

  a_lock_after_run: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(locked) |-> $past(in_window) && $past(enable) &&
    ($past(run) + COUNT_W'(1) >= $past(target)))
    else $error("lock rose without a full in-window run");

  a_miss_restarts: assert property (@(posedge clk) disable iff (!rst_n)
    !in_window |=> (run == '0) && !locked)
    else $error("out-of-window cycle did not restart the run");

  a_zero_count: assert property (@(posedge clk) disable iff (!rst_n)
    (target == '0) |=> !locked)
    else $error("lock asserted with zero count");

  a_reserved_win: assert property (@(posedge clk) disable iff (!rst_n)
    (window == pld_pkg::WIN_RESERVED) |=> !locked)
    else $error("lock asserted with reserved window");
endmodule
`default_nettype wire

// File: pld_lock_ctrl.sv
// serial register port and phase-detector control for the second loop
`timescale 1ns/100ps
`default_nettype none
module pld_lock_ctrl #(
  parameter int COUNT_W = pld_pkg::COUNT_W
) (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // serial register port
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE,
  // phase detector and status pin side
  input  wire logic       PHASE_IN_WINDOW,
  input  wire logic       STATUS_ROUTES_LOCK,
  output logic            PUMP_POLARITY,
  output logic            PUMP_FLOAT,
  output logic [1:0]      PUMP_CURRENT,
  output logic [1:0]      LOCK_WINDOW,
  output logic            LOCK_ACTIVE,
  output logic            LOCK_FLAG
);
  // the count fields are laid out for exactly fourteen bits
  if (COUNT_W != pld_pkg::COUNT_W) begin
    $error("COUNT_W must be 14");
  end

  // keep only the writable bits, reserved bits read back as zero
  function automatic logic [7:0] masked(input logic [7:0] d,
                                        input logic [7:0] m);
    masked = d & m;
  endfunction

  // serial port state
  pld_pkg::pld_spi_st_t state;
  pld_pkg::pld_spi_st_t next_state;
  logic        sck_q;
  logic        sck_rise;
  logic        sck_fall;
  logic [4:0]  bits;
  logic [4:0]  next_bits;
  logic [15:0] sin;
  logic [15:0] next_sin;
  logic [15:0] cmd;
  logic        is_rd;
  logic        next_is_rd;
  logic [14:0] addr;
  logic [14:0] next_addr;
  logic [7:0]  sout;
  logic [7:0]  next_sout;
  logic        sdo;
  logic        next_sdo;
  logic        oe;
  logic        next_oe;
  logic [7:0]  rdata;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        ld_rd;

  // register file state
  pld_pkg::pld_ctrl_t ctrl;
  pld_pkg::pld_ctrl_t next_ctrl;
  logic [7:0]  cnt_high;
  logic [7:0]  next_high;
  logic [7:0]  cnt_low;
  logic [7:0]  next_low;
  logic        active;
  logic        next_active;
  logic        locked;

  // read data for the address just received
  always_comb begin
    cmd   = {sin[14:0], SDI};
    rdata = 8'h00;
    case (cmd[14:0])
      pld_pkg::ADDR_PD_CTRL:   rdata = ctrl;
      pld_pkg::ADDR_CNT_HIGH:  rdata = cnt_high;
      pld_pkg::ADDR_CNT_LOW:   rdata = cnt_low;
      pld_pkg::ADDR_LOCK_STAT: begin
        // lock state is visible here so status pins stay free
        rdata[pld_pkg::STAT_LOCK_BIT]   = locked;
        rdata[pld_pkg::STAT_ACTIVE_BIT] = active;
      end
      default: rdata = 8'h00;
    endcase
  end

  // frame sequencer; sck must stay at least two clocks per phase
  always_comb begin
    sck_rise   = SCK && !sck_q;
    sck_fall   = !SCK && sck_q;
    next_state = state;
    next_bits  = bits;
    next_sin   = sin;
    next_is_rd = is_rd;
    next_addr  = addr;
    next_sout  = sout;
    next_sdo   = sdo;
    next_oe    = oe;
    wr_data    = {sin[6:0], SDI};
    wr_en      = 1'b0;
    ld_rd      = 1'b0;
    case (state)
      pld_pkg::PLD_IDLE: begin
        next_bits = 5'h00;
        if (!CS_N) begin
          next_state = pld_pkg::PLD_CMD;
        end
      end
      pld_pkg::PLD_CMD: begin
        if (sck_rise) begin
          next_sin  = cmd;
          next_bits = bits + 5'h01;
          if (bits == pld_pkg::LAST_CMD_BIT) begin
            next_is_rd = cmd[15];
            next_addr  = cmd[14:0];
            next_sout  = cmd[15] ? rdata : 8'h00; // writes shift out zeros
            next_oe    = cmd[15];
            ld_rd      = cmd[15];
            next_state = pld_pkg::PLD_DATA;
          end
        end
      end
      pld_pkg::PLD_DATA: begin
        if (sck_fall) begin
          // first fall presents bit 7 ahead of the host's next rise
          next_sdo  = sout[7];
          next_sout = {sout[6:0], 1'b0};
        end
        if (sck_rise) begin
          next_sin  = {sin[14:0], SDI};
          next_bits = bits + 5'h01;
          if (bits == pld_pkg::LAST_DATA_BIT) begin
            wr_en      = !is_rd;
            next_state = pld_pkg::PLD_HOLD;
          end
        end
      end
      pld_pkg::PLD_HOLD: begin
        // extra clocks after the last bit are ignored
        next_bits = bits;
      end
      default: next_state = pld_pkg::PLD_IDLE;
    endcase
    // deselect aborts any frame; a cut write is dropped
    if (CS_N) begin
      next_state = pld_pkg::PLD_IDLE;
      next_oe    = 1'b0;
      next_sdo   = 1'b0;
      next_bits  = 5'h00;
    end
  end

  // serial port registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= pld_pkg::PLD_IDLE;
      sck_q <= 1'b0;
      bits  <= 5'h00;
      sin   <= 16'h0000;
      is_rd <= 1'b0;
      addr  <= 15'h0000;
      sout  <= 8'h00;
      sdo   <= 1'b0;
      oe    <= 1'b0;
    end else begin
      state <= next_state;
      sck_q <= SCK;
      bits  <= next_bits;
      sin   <= next_sin;
      is_rd <= next_is_rd;
      addr  <= next_addr;
      sout  <= next_sout;
      sdo   <= next_sdo;
      oe    <= next_oe;
    end
  end

  // register writes and lock-detect power
  always_comb begin
    next_ctrl = ctrl;
    next_high = cnt_high;
    next_low  = cnt_low;
    if (wr_en) begin
      case (addr)
        pld_pkg::ADDR_PD_CTRL:
          next_ctrl = pld_pkg::pld_ctrl_t'(
                        masked(wr_data, pld_pkg::CTRL_WMASK));
        pld_pkg::ADDR_CNT_HIGH:
          next_high = masked(wr_data, pld_pkg::CNT_HIGH_WMASK);
        pld_pkg::ADDR_CNT_LOW:
          next_low = masked(wr_data, pld_pkg::CNT_LOW_WMASK);
        default: next_low = cnt_low;
      endcase
    end
    // forced on, or powered only while a pin carries the flag
    next_active = ctrl.force_on || STATUS_ROUTES_LOCK;
  end

  // register file
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl     <= pld_pkg::pld_ctrl_t'(pld_pkg::CTRL_RST);
      cnt_high <= pld_pkg::CNT_HIGH_RST;
      cnt_low  <= pld_pkg::CNT_LOW_RST;
      active   <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      cnt_high <= next_high;
      cnt_low  <= next_low;
      active   <= next_active;
    end
  end

  // the run counter is cleared whenever power is withheld
  pld_lock_counter #(
    .COUNT_W (COUNT_W)
  ) u_counter (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .enable    (active),
    .window    (ctrl.window),
    .target    ({cnt_high[5:0], cnt_low}),
    .in_window (PHASE_IN_WINDOW),
    .locked    (locked)
  );

  // outputs straight from the register flops
  assign PUMP_POLARITY = ctrl.polarity;
  assign PUMP_FLOAT    = ctrl.pump_float;
  assign PUMP_CURRENT  = ctrl.current;
  assign LOCK_WINDOW   = ctrl.window;
  assign LOCK_ACTIVE   = active;
  assign LOCK_FLAG     = locked;
  assign SDO           = sdo;
  assign SDO_OE        = oe;

  a_pol_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && (addr == pld_pkg::ADDR_PD_CTRL)
    |=> PUMP_POLARITY == $past(wr_data[2]))
    else $error("polarity did not follow its write");

  a_float_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && (addr == pld_pkg::ADDR_PD_CTRL)
    |=> PUMP_FLOAT == $past(wr_data[1]))
    else $error("pump float did not follow its write");

  a_power_gated: assert property (@(posedge MCLK) disable iff (!RST_N)
    !ctrl.force_on && !STATUS_ROUTES_LOCK |=> !LOCK_ACTIVE)
    else $error("lock detect powered with no pin route");

  a_power_forced: assert property (@(posedge MCLK) disable iff (!RST_N)
    ctrl.force_on |=> LOCK_ACTIVE)
    else $error("forced lock detect not powered");

  a_stat_readback: assert property (@(posedge MCLK) disable iff (!RST_N)
    ld_rd && (cmd[14:0] == pld_pkg::ADDR_LOCK_STAT)
    |=> sout[pld_pkg::STAT_LOCK_BIT] == $past(LOCK_FLAG))
    else $error("status readback missed the lock flag");

  a_high_field: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && (addr == pld_pkg::ADDR_CNT_HIGH)
    |=> cnt_high == {2'b00, $past(wr_data[5:0])})
    else $error("count high field wrong after write");

  a_window_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && (addr == pld_pkg::ADDR_PD_CTRL)
    |=> LOCK_WINDOW == $past(wr_data[6:5]))
    else $error("window did not follow its write");

  a_oe_read_only: assert property (@(posedge MCLK) disable iff (!RST_N)
    SDO_OE |-> is_rd && (state != pld_pkg::PLD_IDLE))
    else $error("data line driven outside a read frame");

  a_sdo_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    !SDO_OE |-> !SDO)
    else $error("data line not low while released");
endmodule
`default_nettype wire

// File: pld_host_model.sv
// host model that drives whole and cut serial register frames into the block
`timescale 1ns/100ps
`default_nettype none
module pld_host_model (
  // clock
  input  wire logic       MCLK,
  // serial port
  output var  logic       SCK,
  output var  logic       CS_N,
  output var  logic       SDI,
  input  wire logic       SDO,
  // read result, one-cycle pulse after a read frame
  output var  logic       rd_valid,
  output var  logic [7:0] rd_data
);
  // idle: deselected, serial clock standing low
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end

  // one frame msb first, 4 cycles low and 3 high per bit
  // caller picks polarity for its oscillator and trusts status when valid
  task automatic frame(input logic rd, input logic [14:0] addr,
                       input logic [7:0] wd);
    logic [23:0] v;
    v = {rd, addr, wd};
    @(posedge MCLK) CS_N <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge MCLK) SDI <= v[i];
      repeat (3) @(posedge MCLK);
      SCK <= 1'b1;
      // data bits are sampled at the rise, long after the shifting fall
      if (i < 8) rd_data[i] <= SDO;
      repeat (3) @(posedge MCLK);
      SCK <= 1'b0;
    end
    repeat (3) @(posedge MCLK);
    CS_N <= 1'b1;
    SDI <= ~SDI;  // released line must not keep showing the last bit
    rd_valid <= rd;
    @(posedge MCLK) rd_valid <= 1'b0;
    repeat (2) @(posedge MCLK);
  endtask

  // a write frame deselected after n bits, same bit timing as frame
  task automatic cut_frame(input logic [14:0] addr, input logic [7:0] wd,
                           input int n);
    logic [23:0] v;
    v = {1'b0, addr, wd};
    @(posedge MCLK) CS_N <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      @(posedge MCLK) SDI <= v[i];
      repeat (3) @(posedge MCLK);
      SCK <= 1'b1;
      repeat (3) @(posedge MCLK);
      SCK <= 1'b0;
    end
    repeat (3) @(posedge MCLK);
    CS_N <= 1'b1;
    SDI <= ~SDI;
    repeat (3) @(posedge MCLK);
  endtask
endmodule
`default_nettype wire

// File: pll_b_lock_detect_control_tb.sv
// self-checking bench for the second-loop lock-detect control block
`timescale 1ns/100ps
`default_nettype none
module pll_b_lock_detect_control_tb;
  localparam logic [14:0] A_CTRL = pld_pkg::ADDR_PD_CTRL;
  localparam logic [14:0] A_HI   = pld_pkg::ADDR_CNT_HIGH;
  localparam logic [14:0] A_LO   = pld_pkg::ADDR_CNT_LOW;
  localparam logic [14:0] A_ST   = pld_pkg::ADDR_LOCK_STAT;
  logic        MCLK, RST_N, SCK, CS_N, SDI, SDO, SDO_OE, rd_valid;
  logic        PHASE_IN_WINDOW, STATUS_ROUTES_LOCK;
  logic        PUMP_POLARITY, PUMP_FLOAT, LOCK_ACTIVE, LOCK_FLAG;
  logic [1:0]  PUMP_CURRENT, LOCK_WINDOW;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h7c0b0e8a;
  logic        oe_seen = 1'b0;

  initial MCLK = 1'b0;
  always #25 MCLK = ~MCLK;

  pld_lock_ctrl dut_u (.MCLK(MCLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N),
    .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE),
    .PHASE_IN_WINDOW(PHASE_IN_WINDOW),
    .STATUS_ROUTES_LOCK(STATUS_ROUTES_LOCK),
    .PUMP_POLARITY(PUMP_POLARITY), .PUMP_FLOAT(PUMP_FLOAT),
    .PUMP_CURRENT(PUMP_CURRENT), .LOCK_WINDOW(LOCK_WINDOW),
    .LOCK_ACTIVE(LOCK_ACTIVE), .LOCK_FLAG(LOCK_FLAG));
  pld_host_model host_u (.MCLK(MCLK), .SCK(SCK), .CS_N(CS_N), .SDI(SDI),
    .SDO(SDO), .rd_valid(rd_valid), .rd_data(rd_data));

  // random source for the free control bits
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // control pins gathered in register bit order, force bit not visible
  function automatic logic [7:0] pins();
    return {1'b0, LOCK_WINDOW, PUMP_CURRENT, PUMP_POLARITY, PUMP_FLOAT,
            1'b0};
  endfunction
  task automatic check_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_bit(input string what, input logic e,
                           input logic g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host_u.frame(1'b0, a, d);
    // a write frame must never turn the data line around
    check_bit("sdo_oe_seen", 1'b0, oe_seen);
  endtask
  // the expected byte is noted before the frame goes out
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.frame(1'b1, a, 8'h00);
  endtask
  // n in-window samples, then one out: flag after n-th, then dropped
  task automatic hold_in(input int n, input logic e);
    @(posedge MCLK) PHASE_IN_WINDOW <= 1'b1;
    repeat (n) @(posedge MCLK);
    PHASE_IN_WINDOW <= 1'b0;
    #1 check_bit("lock_flag", e, LOCK_FLAG);
    @(posedge MCLK) #1 check_bit("lock_flag", 1'b0, LOCK_FLAG);
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watcher: every read result takes the oldest note
  always @(posedge MCLK) begin
    if (SDO_OE === 1'b1)
      oe_seen <= 1'b1;
    if (rd_valid === 1'b1) begin
      // the data line must have been driven during the read
      check_bit("sdo_oe_seen", 1'b1, oe_seen);
      oe_seen <= 1'b0;
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("ERROR read_data expected none seen %h", rd_data);
      end else
        check_byte("read_data", exp_q.pop_front(), rd_data);
    end
  end

  // hang guard, about three times the expected run
  initial begin
    repeat (20000) @(posedge MCLK);
    n_fail++;
    report_and_stop;
  end

  initial begin
    logic [7:0] d;
    RST_N = 1'b0;
    PHASE_IN_WINDOW = 1'b0;
    STATUS_ROUTES_LOCK = 1'b0;
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    #1 check_byte("ctrl_pins", pld_pkg::CTRL_RST & 8'h7e, pins());
    check_bit("lock_flag", 1'b0, LOCK_FLAG);
    check_bit("sdo_oe", 1'b0, SDO_OE);
    rd(A_CTRL, pld_pkg::CTRL_RST);
    rd(A_HI, pld_pkg::CNT_HIGH_RST);
    rd(A_LO, pld_pkg::CNT_LOW_RST);
    end_test("reset");
    // every polarity and float pairing, force bit clear, bits 7 to 3 random
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d = {seed[7:3], k[1], k[0], 1'b0};
      wr(A_CTRL, d);
      #1 check_byte("ctrl_pins", d & 8'h7e, pins());
      rd(A_CTRL, d & pld_pkg::CTRL_WMASK);
    end
    wr(A_HI, 8'hff);
    wr(A_LO, 8'hff);
    rd(A_HI, pld_pkg::CNT_HIGH_WMASK);
    rd(A_LO, 8'hff);
    // a write cut one bit short must leave the byte alone
    host_u.cut_frame(A_LO, 8'h55, 23);
    rd(A_LO, 8'hff);
    wr(15'h0170, 8'ha5);
    rd(15'h0170, 8'h00);
    wr(A_ST, 8'hff);
    rd(A_ST, 8'h00);
    end_test("registers");
    // count 3, window 1, positive-slope oscillator assumed
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h03);
    wr(A_CTRL, 8'h24);
    #1 check_bit("lock_active", 1'b0, LOCK_ACTIVE);
    hold_in(3, 1'b0);
    @(posedge MCLK) STATUS_ROUTES_LOCK <= 1'b1;
    repeat (2) @(posedge MCLK);
    #1 check_bit("lock_active", 1'b1, LOCK_ACTIVE);
    hold_in(3, 1'b1);
    @(posedge MCLK) STATUS_ROUTES_LOCK <= 1'b0;
    wr(A_CTRL, 8'h65);
    #1 check_bit("lock_active", 1'b1, LOCK_ACTIVE);
    hold_in(2, 1'b0);
    hold_in(3, 1'b1);
    // status read while locked and forced, no pin routing
    @(posedge MCLK) PHASE_IN_WINDOW <= 1'b1;
    rd(A_ST, 8'h03);
    @(posedge MCLK) PHASE_IN_WINDOW <= 1'b0;
    wr(A_LO, 8'h00);
    hold_in(5, 1'b0);
    wr(A_LO, 8'h03);
    wr(A_CTRL, 8'h05);
    hold_in(5, 1'b0);
    // count 0x101 spans both bytes
    wr(A_HI, 8'h01);
    wr(A_LO, 8'h01);
    wr(A_CTRL, 8'h45);
    hold_in(256, 1'b0);
    hold_in(257, 1'b1);
    end_test("lock");
    report_and_stop;
  end
endmodule
`default_nettype wire
